// file: rtl/wdt_ext_core.sv
`timescale 1ns/1ns
// Summary of operation
// - Clear file writes zero, sets zero flag
// - Watchdog clear zeroes the watchdog counter
// - Watchdog clear also zeroes the postscaler
// - Watchdog clear sets timeout and powerdown bits
// - Watchdog clear: one word, one cycle
// - Extension off by default, config bit enables
// - Byte and bit ops gain indexed mode
// - Access bit clear, f<=5Fh uses indexed
// - Pointer add/sub: select, literal, one cycle for selects 00-10
// - Select 11 adjusts third pointer, returns
// - Subtract-and-return lowers third pointer, two cycles
// - Call via working register, two cycles
// - Indexed to absolute move, two words
// - Indexed to indexed move, two words
// - Push literal at third pointer, decrement
module wdt_ext_core #(
    parameter int WDT_WIDTH  = 5,
    parameter int POST_WIDTH = 18
) (
    input  wire logic                      CLOCK,
    input  wire logic                      SRST,
    input  wire logic                      INSTR_VALID,
    input  wire logic [15:0]               INSTR_WORD,
    input  wire logic                      EXTENDED_SET_ENABLE_CFG,
    input  wire logic [7:0]                WORKING_REGISTER,
    input  wire logic [3:0]                BANK_SELECT_REGISTER,
    input  wire logic                      WDT_TICK,
    input  wire logic                      SLEEP_EXEC,
    input  wire logic [7:0]                RD_DATA,
    output logic                           INSTR_READY,
    output logic [11:0]                    EFFECTIVE_ADDR,
    output logic                           INDEXED_MODE,
    output logic [WDT_WIDTH-1:0]           WATCHDOG_COUNTER,
    output logic [POST_WIDTH-1:0]          WDT_POSTSCALER,
    output logic                           TIMEOUT_STATUS_BIT,
    output logic                           POWERDOWN_STATUS_BIT,
    output logic                           WDT_EXPIRED,
    output logic                           ZERO_FLAG_SET,
    output wdt_ext_pkg::mem_req_type       MEM_WR,
    output logic                           MEM_RD_EN,
    output logic [11:0]                    MEM_RD_ADDR,
    output logic                           RETURN_REQ,
    output logic                           CALL_REQ,
    output logic [7:0]                     CALL_TARGET_LOW,
    output logic [35:0]                    FILE_POINTER_REG
);

    if (WDT_WIDTH < 1 || WDT_WIDTH > 16 || POST_WIDTH < 1 || POST_WIDTH > 24) begin : gen_chk
        $error("wdt_ext_core: unsupported counter widths");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Byte and bit instructions that carry an access bit
    function automatic logic has_access_bit(input logic [15:0] w);
        logic [3:0] top;
        top = w[15:12];
        return (top >= 4'h1 && top <= 4'hB) || (top == 4'h0 && w[15:10] != 6'h00);
    endfunction : has_access_bit

    function automatic logic ext_prefix(input logic [15:0] w, input logic [7:0] p);
        return w[15:8] == p;
    endfunction : ext_prefix

    wdt_ext_pkg::exec_state_type state_ff;
    wdt_ext_pkg::exec_state_type nxt_state;
    logic [11:0]                 ptr_ff [3];
    logic [11:0]                 nxt_ptr [3];
    logic                        ext_on;
    logic                        take;
    logic                        is_wdt_clear;
    logic                        is_clear_file;
    logic                        is_ptr_add;
    logic                        is_ptr_sub;
    logic                        is_push;
    logic                        is_move;
    logic                        is_call_via_working_op;
    logic                        ptr_third;
    logic                        move_idx_dest_ff;
    logic                        rd_pending_ff;
    logic [7:0]                  rd_hold_ff;
    logic [7:0]                  move_data;
    logic [5:0]                  lit6;
    logic [1:0]                  sel;
    logic [1:0]                  ptr_idx;
    logic [POST_WIDTH-1:0]       post_ff;
    logic [WDT_WIDTH-1:0]        wdt_ff;
    logic                        to_ff;
    logic                        pd_ff;
    logic                        expired_ff;

    // Extension opcodes only start while the configuration bit is set; a move's second-word write is not gated
    // enable gating
    assign ext_on = EXTENDED_SET_ENABLE_CFG;
    assign take   = INSTR_VALID && INSTR_READY && state_ff != wdt_ext_pkg::ST_WORD_TWO;
    assign lit6   = INSTR_WORD[5:0];
    assign sel    = INSTR_WORD[wdt_ext_pkg::PTR_SEL_MSB:wdt_ext_pkg::PTR_SEL_LSB];

    assign is_wdt_clear  = take && INSTR_WORD == wdt_ext_pkg::WATCHDOG_CLEAR_WORD;
    assign is_clear_file = take && INSTR_WORD[15:9] == wdt_ext_pkg::CLEAR_FILE_PREFIX;
    assign is_ptr_add = take && ext_on && ext_prefix(INSTR_WORD, wdt_ext_pkg::POINTER_ADD_PREFIX);
    assign is_ptr_sub = take && ext_on && ext_prefix(INSTR_WORD, wdt_ext_pkg::POINTER_SUB_PREFIX);
    assign is_push    = take && ext_on && ext_prefix(INSTR_WORD, wdt_ext_pkg::PUSH_LITERAL_PREFIX);
    assign is_move    = take && ext_on && ext_prefix(INSTR_WORD, wdt_ext_pkg::MOVE_PREFIX);
    assign is_call_via_working_op   = take && ext_on && INSTR_WORD == wdt_ext_pkg::CALL_VIA_WORKING_WORD;
    assign ptr_third  = sel == wdt_ext_pkg::THIRD_POINTER_SEL;
    // Select 11 is the return form; it still works on the third pointer
    assign ptr_idx    = ptr_third ? 2'h2 : sel;

    ////////////////////////////////////////////////////////////////////////////
    // File operand addressing

    always_comb begin
        logic [7:0] f;
        f              = INSTR_WORD[7:0];
        INDEXED_MODE   = 1'b0;
        EFFECTIVE_ADDR = 12'h000;
        if (INSTR_WORD[wdt_ext_pkg::ACCESS_BIT_POS]) begin
            EFFECTIVE_ADDR = {BANK_SELECT_REGISTER, f};
        end else if (ext_on && f <= wdt_ext_pkg::INDEXED_LIMIT) begin
            INDEXED_MODE   = has_access_bit(INSTR_WORD);
            EFFECTIVE_ADDR = ptr_ff[2] + {4'h0, f};
        end else if (f <= wdt_ext_pkg::INDEXED_LIMIT) begin
            EFFECTIVE_ADDR = {wdt_ext_pkg::ACCESS_LOW_BANK, f};
        end else begin
            EFFECTIVE_ADDR = {wdt_ext_pkg::ACCESS_HIGH_BANK, f};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing

    // Dead second cycles stall the fetch side
    assign INSTR_READY = state_ff != wdt_ext_pkg::ST_DEAD;

    always_comb begin
        nxt_state = wdt_ext_pkg::ST_FIRST;
        case (state_ff)
            wdt_ext_pkg::ST_FIRST: begin
                if (((is_ptr_add || is_ptr_sub) && ptr_third) || is_call_via_working_op) begin
                    nxt_state = wdt_ext_pkg::ST_DEAD;
                end else if (is_move) begin
                    nxt_state = wdt_ext_pkg::ST_WORD_TWO;
                end
            end
            wdt_ext_pkg::ST_DEAD: nxt_state = wdt_ext_pkg::ST_FIRST;
            wdt_ext_pkg::ST_WORD_TWO: begin
                nxt_state = INSTR_VALID ? wdt_ext_pkg::ST_FIRST : wdt_ext_pkg::ST_WORD_TWO;
            end
            default: nxt_state = wdt_ext_pkg::ST_FIRST;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_ff <= wdt_ext_pkg::ST_FIRST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // File pointers

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_ptr[i] = ptr_ff[i];
        end
        if (is_ptr_add) begin
            nxt_ptr[ptr_idx] = ptr_ff[ptr_idx] + {6'h00, lit6};
        end
        if (is_ptr_sub) begin
            nxt_ptr[ptr_idx] = ptr_ff[ptr_idx] - {6'h00, lit6};
        end
        if (is_push) begin
            nxt_ptr[2] = ptr_ff[2] - 12'h001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ptr
            always_ff @(posedge CLOCK) begin
                if (SRST) begin
                    ptr_ff[g] <= wdt_ext_pkg::POINTER_RESET;
                end else begin
                    ptr_ff[g] <= nxt_ptr[g];
                end
            end
            assign FILE_POINTER_REG[g*12 +: 12] = ptr_ff[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Control transfer requests

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            RETURN_REQ      <= 1'b0;
            CALL_REQ        <= 1'b0;
            CALL_TARGET_LOW <= 8'h00;
        end else begin
            RETURN_REQ <= (is_ptr_add || is_ptr_sub) && ptr_third;
            CALL_REQ <= is_call_via_working_op;
            if (is_call_via_working_op) begin
                CALL_TARGET_LOW <= WORKING_REGISTER;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory traffic

    // Source byte is live while the read strobe stands, then held
    assign move_data = rd_pending_ff ? RD_DATA : rd_hold_ff;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            MEM_RD_EN        <= 1'b0;
            MEM_RD_ADDR      <= 12'h000;
            rd_pending_ff    <= 1'b0;
            rd_hold_ff       <= 8'h00;
            move_idx_dest_ff <= 1'b0;
        end else begin
            MEM_RD_EN     <= is_move;
            rd_pending_ff <= is_move;
            if (is_move) begin
                MEM_RD_ADDR      <= ptr_ff[2] + {5'h00, INSTR_WORD[6:0]};
                move_idx_dest_ff <= INSTR_WORD[wdt_ext_pkg::MOVE_KIND_POS];
            end
            if (rd_pending_ff) begin
                rd_hold_ff <= RD_DATA;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            MEM_WR        <= '0;
            ZERO_FLAG_SET <= 1'b0;
        end else begin
            MEM_WR.en     <= 1'b0;
            ZERO_FLAG_SET <= 1'b0;
            if (is_clear_file) begin
                MEM_WR        <= '{en: 1'b1, addr: EFFECTIVE_ADDR, data: 8'h00};
                ZERO_FLAG_SET <= 1'b1;
            end else if (is_push) begin
                MEM_WR <= '{en: 1'b1, addr: ptr_ff[2], data: INSTR_WORD[7:0]};
            end else if (state_ff == wdt_ext_pkg::ST_WORD_TWO && INSTR_VALID &&
                         INSTR_WORD[15:12] == wdt_ext_pkg::SECOND_WORD_PREFIX) begin
                if (move_idx_dest_ff) begin
                    MEM_WR <= '{en: 1'b1, addr: ptr_ff[2] + {5'h00, INSTR_WORD[6:0]},
                                data: move_data};
                end else begin
                    MEM_WR <= '{en: 1'b1, addr: INSTR_WORD[11:0], data: move_data};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            post_ff    <= '0;
            wdt_ff     <= '0;
            expired_ff <= 1'b0;
        end else begin
            expired_ff <= 1'b0;
            if (is_wdt_clear) begin
                wdt_ff  <= '0;
                post_ff <= '0;
            end else if (WDT_TICK) begin
                post_ff <= post_ff + 1'b1;
                if (&post_ff) begin
                    wdt_ff     <= wdt_ff + 1'b1;
                    expired_ff <= &wdt_ff;
                end
            end
        end
    end

    // A clear in the same cycle as a time-out wins: the time-out is already void
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            to_ff <= wdt_ext_pkg::TIMEOUT_RESET;
            pd_ff <= wdt_ext_pkg::POWERDOWN_RESET;
        end else if (is_wdt_clear) begin
            to_ff <= 1'b1;
            pd_ff <= 1'b1;
        end else begin
            if (expired_ff) begin
                to_ff <= 1'b0;
            end
            if (SLEEP_EXEC) begin
                pd_ff <= 1'b0;
            end
        end
    end

    assign WATCHDOG_COUNTER     = wdt_ff;
    assign WDT_POSTSCALER       = post_ff;
    assign TIMEOUT_STATUS_BIT   = to_ff;
    assign POWERDOWN_STATUS_BIT = pd_ff;
    assign WDT_EXPIRED          = expired_ff;

endmodule : wdt_ext_core

// file: rtl/wdt_ext_pkg.sv
package wdt_ext_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode patterns
    localparam logic [15:0] WATCHDOG_CLEAR_WORD = 16'h0004;
    localparam logic [15:0] CALL_VIA_WORKING_WORD = 16'h0014;
    localparam logic [6:0]  CLEAR_FILE_PREFIX   = 7'h35;
    localparam logic [7:0]  POINTER_ADD_PREFIX  = 8'hE8;
    localparam logic [7:0]  POINTER_SUB_PREFIX  = 8'hE9;
    localparam logic [7:0]  PUSH_LITERAL_PREFIX = 8'hEA;
    localparam logic [7:0]  MOVE_PREFIX         = 8'hEB;
    localparam logic [3:0]  SECOND_WORD_PREFIX  = 4'hF;
    localparam logic [1:0]  THIRD_POINTER_SEL   = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ACCESS_BIT_POS  = 8;
    localparam int MOVE_KIND_POS   = 7;
    localparam int PTR_SEL_MSB     = 7;
    localparam int PTR_SEL_LSB     = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Addressing
    localparam logic [7:0] INDEXED_LIMIT    = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        TIMEOUT_RESET   = 1'b1;
    localparam logic        POWERDOWN_RESET = 1'b1;
    localparam logic [11:0] POINTER_RESET   = 12'h000;

    typedef struct packed {
        logic        en;
        logic [11:0] addr;
        logic [7:0]  data;
    } mem_req_type;

    typedef enum logic [1:0] {
        ST_FIRST    = 2'b00,
        ST_DEAD     = 2'b01,
        ST_WORD_TWO = 2'b10
    } exec_state_type;

endpackage : wdt_ext_pkg

// file: dv/wdt_ext_core_asserts.sv
`timescale 1ns/1ns
module wdt_ext_core_asserts #(
    parameter int WDT_WIDTH  = 5,
    parameter int POST_WIDTH = 18
) (
    input wire logic                     CLOCK,
    input wire logic                     SRST,
    input wire logic                     INSTR_VALID,
    input wire logic [15:0]              INSTR_WORD,
    input wire logic                     EXTENDED_SET_ENABLE_CFG,
    input wire logic [7:0]               WORKING_REGISTER,
    input wire logic [7:0]               RD_DATA,
    input wire logic                     INSTR_READY,
    input wire logic                     INDEXED_MODE,
    input wire logic [WDT_WIDTH-1:0]     WATCHDOG_COUNTER,
    input wire logic [POST_WIDTH-1:0]    WDT_POSTSCALER,
    input wire logic                     TIMEOUT_STATUS_BIT,
    input wire logic                     POWERDOWN_STATUS_BIT,
    input wire logic                     WDT_EXPIRED,
    input wire logic                     ZERO_FLAG_SET,
    input wire wdt_ext_pkg::mem_req_type MEM_WR,
    input wire logic                     MEM_RD_EN,
    input wire logic                     RETURN_REQ,
    input wire logic                     CALL_REQ,
    input wire logic [7:0]               CALL_TARGET_LOW,
    input wire logic [35:0]              FILE_POINTER_REG
);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the move state, so a second word is never read as a new opcode
    logic        two_ff;
    logic [15:0] word_ff;
    logic [11:0] third_ff;
    logic [7:0]  src_ff;
    // Source byte is live while the read strobe stands, held afterwards
    wire  [7:0]  src_now = MEM_RD_EN ? RD_DATA : src_ff;
    wire         take = INSTR_VALID && INSTR_READY && !two_ff;
    wire         ext  = EXTENDED_SET_ENABLE_CFG;
    always_ff @(posedge CLOCK) begin
        if (SRST) two_ff <= 1'b0;
        else if (INSTR_VALID && INSTR_READY) two_ff <= take && ext && INSTR_WORD[15:8] == 8'hEB;
    end
    always_ff @(posedge CLOCK) begin
        word_ff  <= INSTR_WORD;
        third_ff <= FILE_POINTER_REG[35:24];
        if (MEM_RD_EN) src_ff <= RD_DATA;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    wdt_clear_a: assert property (take && INSTR_WORD == wdt_ext_pkg::WATCHDOG_CLEAR_WORD
        |=> WATCHDOG_COUNTER == '0 && WDT_POSTSCALER == '0) else $error("watchdog not cleared");
    status_set_a: assert property (take && INSTR_WORD == 16'h0004
        |=> TIMEOUT_STATUS_BIT && POWERDOWN_STATUS_BIT) else $error("status bits not set");
    clear_file_a: assert property (take && INSTR_WORD[15:9] == 7'h35
        |=> MEM_WR.en && MEM_WR.data == 8'h00 && ZERO_FLAG_SET) else $error("clear file bad");
    indexed_sel_a: assert property (INSTR_VALID && !two_ff && INSTR_WORD[15:9] == 7'h35
        |-> INDEXED_MODE == (ext && !INSTR_WORD[8] && INSTR_WORD[7:0] <= 8'h5F))
        else $error("indexed mode wrong");
    ext_off_a: assert property (take && !ext && INSTR_WORD[15:10] == 6'h3A
        |=> !MEM_WR.en && !RETURN_REQ && !MEM_RD_EN && $stable(FILE_POINTER_REG))
        else $error("extended op ran while off");
    ptr_return_a: assert property (take && ext && INSTR_WORD[15:9] == 7'h74
        && INSTR_WORD[7:6] == 2'h3 |=> RETURN_REQ && !INSTR_READY ##1 INSTR_READY)
        else $error("return timing wrong");
    third_adj_a: assert property (take && ext && INSTR_WORD[15:9] == 7'h74 && &INSTR_WORD[7:6]
        |=> FILE_POINTER_REG[35:24] == (word_ff[8] ? third_ff - {6'h00, word_ff[5:0]}
        : third_ff + {6'h00, word_ff[5:0]})) else $error("third pointer adjust wrong");
    push_lit_a: assert property (take && ext && INSTR_WORD[15:8] == 8'hEA |=> MEM_WR.en
        && MEM_WR.addr == third_ff && MEM_WR.data == word_ff[7:0]
        && FILE_POINTER_REG[35:24] == third_ff - 12'h001) else $error("push literal wrong");
    call_work_a: assert property (take && ext && INSTR_WORD == 16'h0014 |=> CALL_REQ
        && CALL_TARGET_LOW == $past(WORKING_REGISTER) && !INSTR_READY) else $error("call bad");
    move_write_a: assert property (two_ff && INSTR_VALID && INSTR_WORD[15:12] == 4'hF
        |=> MEM_WR.en && MEM_WR.data == $past(src_now)) else $error("move write wrong");
    timeout_clr_a: assert property (WDT_EXPIRED && !(take && INSTR_WORD == 16'h0004)
        |=> !TIMEOUT_STATUS_BIT) else $error("timeout bit not cleared");
    cover property (take && INSTR_WORD == 16'h0004);
    cover property (two_ff && INSTR_VALID);
    cover property (RETURN_REQ ##1 INSTR_READY);
    cover property (WDT_EXPIRED);
endmodule : wdt_ext_core_asserts

bind wdt_ext_core wdt_ext_core_asserts #(.WDT_WIDTH(WDT_WIDTH), .POST_WIDTH(POST_WIDTH))
    u_wdt_ext_core_asserts (.CLOCK(CLOCK), .SRST(SRST), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .EXTENDED_SET_ENABLE_CFG(EXTENDED_SET_ENABLE_CFG),
    .WORKING_REGISTER(WORKING_REGISTER), .RD_DATA(RD_DATA), .INSTR_READY(INSTR_READY),
    .INDEXED_MODE(INDEXED_MODE), .WATCHDOG_COUNTER(WATCHDOG_COUNTER),
    .WDT_POSTSCALER(WDT_POSTSCALER), .TIMEOUT_STATUS_BIT(TIMEOUT_STATUS_BIT),
    .POWERDOWN_STATUS_BIT(POWERDOWN_STATUS_BIT), .ZERO_FLAG_SET(ZERO_FLAG_SET),
    .WDT_EXPIRED(WDT_EXPIRED),
    .MEM_WR(MEM_WR), .MEM_RD_EN(MEM_RD_EN), .RETURN_REQ(RETURN_REQ), .CALL_REQ(CALL_REQ),
    .CALL_TARGET_LOW(CALL_TARGET_LOW), .FILE_POINTER_REG(FILE_POINTER_REG));

// file: dv/test_wdt_ext_core.sv
`timescale 1ns/1ns
module test_wdt_ext_core;
    logic                     clock = 1'b0;
    logic                     srst  = 1'b1;
    logic                     valid = 1'b0;
    logic [15:0]              word  = 16'h0000;
    logic                     ext   = 1'b0;
    logic [7:0]               working_register  = 8'h00;
    logic                     tick  = 1'b0;
    logic                     sleep = 1'b0;
    logic [7:0]               rd    = 8'h00;
    logic [3:0]               bank_select_register   = 4'h2;
    logic                     ready, ex_mode, mode_q, to_bit, pd_bit, zf, ret, call, rd_en;
    logic                     expd;
    logic [11:0]              eff, rd_addr;
    logic [1:0]               wdt;
    logic [1:0]               post;
    logic [7:0]               tgt;
    logic [35:0]              ptr;
    wdt_ext_pkg::mem_req_type wr;
    int                       mismatches = 0;
    int                       num_checks = 0;

    // Narrow counters so that a full watchdog wrap fits in the run
    wdt_ext_core #(.WDT_WIDTH(2), .POST_WIDTH(2)) u_wdt_ext_core (
        .CLOCK(clock), .SRST(srst), .INSTR_VALID(valid),
        .INSTR_WORD(word), .EXTENDED_SET_ENABLE_CFG(ext), .WORKING_REGISTER(working_register),
        .BANK_SELECT_REGISTER(bank_select_register), .WDT_TICK(tick), .SLEEP_EXEC(sleep), .RD_DATA(rd),
        .INSTR_READY(ready), .EFFECTIVE_ADDR(eff), .INDEXED_MODE(ex_mode),
        .WATCHDOG_COUNTER(wdt), .WDT_POSTSCALER(post), .TIMEOUT_STATUS_BIT(to_bit),
        .POWERDOWN_STATUS_BIT(pd_bit), .WDT_EXPIRED(expd), .ZERO_FLAG_SET(zf), .MEM_WR(wr),
        .MEM_RD_EN(rd_en), .MEM_RD_ADDR(rd_addr), .RETURN_REQ(ret), .CALL_REQ(call),
        .CALL_TARGET_LOW(tgt), .FILE_POINTER_REG(ptr));

    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task check(string name, logic [35:0] seen, logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Leading edge wait also lets a dead second cycle pass
    task issue(logic [15:0] w);
        @(posedge clock);
        #1 valid = 1'b1;
        word = w;
        #1 mode_q = ex_mode;
        @(posedge clock);
        #1 valid = 1'b0;
    endtask : issue

    task move(logic [15:0] w1, logic [15:0] w2, logic [7:0] d, logic [11:0] src);
        @(posedge clock);
        #1 valid = 1'b1;
        word = w1;
        @(posedge clock);
        #1 check("read addr", rd_addr, src);
        check("read strobe", rd_en, 36'h1);
        word = w2;
        rd = d;
        @(posedge clock);
        #1 valid = 1'b0;
        rd = ~d;
        check("move data", wr.data, d);
    endtask : move

    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    task ticks(int n);
        repeat (n) begin
            @(posedge clock);
            #1 tick = 1'b1;
            @(posedge clock);
            #1 tick = 1'b0;
        end
    endtask : ticks

    task t_watchdog();
        // Sixteen ticks wrap both two-bit counters
        ticks(16);
        check("expired", expd, 36'h1);
        @(posedge clock);
        #1 check("timeout cleared", to_bit, 36'h0);
        ticks(5);
        @(posedge clock);
        #1 sleep = 1'b1;
        @(posedge clock);
        #1 sleep = 1'b0;
        check("counter before", wdt, 36'h1);
        check("postscaler before", post, 36'h1);
        check("powerdown", pd_bit, 36'h0);
        issue(wdt_ext_pkg::WATCHDOG_CLEAR_WORD);
        check("one cycle", ready, 36'h1);
        check("counter", wdt, 36'h0);
        check("postscaler", post, 36'h0);
        check("timeout", to_bit, 36'h1);
        check("powerdown", pd_bit, 36'h1);
        check("no write", wr.en, 36'h0);
    endtask : t_watchdog

    task t_ext_off();
        check("indexed default", ex_mode, 36'h0);
        issue(16'hE8C3);
        check("no return", ret, 36'h0);
        check("pointers", ptr, 36'h0);
        issue(16'hEB05);
        check("no read", rd_en, 36'h0);
        issue(16'h6A10);
        check("plain mode", mode_q, 36'h0);
        check("access addr", wr.addr, 36'h010);
        check("clear data", wr.data, 36'h0);
        check("zero flag", zf, 36'h1);
        bank_select_register = 4'h5;
        issue(16'h6B20);
        check("bank addr", wr.addr, 36'h520);
        check("eff addr", eff, 36'h520);
    endtask : t_ext_off

    task t_pointers();
        ext = 1'b1;
        issue(16'hE805);
        check("ptr0", ptr[11:0], 36'h005);
        issue(16'hE845);
        issue(16'hE941);
        check("ptr1", ptr[23:12], 36'h004);
        check("no return", ret, 36'h0);
        issue(16'hE8CA);
        check("third add", ptr[35:24], 36'h00A);
        check("return", ret, 36'h1);
        check("dead cycle", ready, 36'h0);
        @(posedge clock);
        #1 check("ready again", ready, 36'h1);
        issue(16'hE9C1);
        check("third sub", ptr[35:24], 36'h009);
        check("return", ret, 36'h1);
    endtask : t_pointers

    task t_extended_ops();
        issue(16'h6A10);
        check("indexed", mode_q, 36'h1);
        check("indexed addr", wr.addr, 36'h019);
        issue(16'h6A60);
        check("above limit", mode_q, 36'h0);
        check("high access", wr.addr, 36'hF60);
        issue(16'hEA7F);
        check("push addr", wr.addr, 36'h009);
        check("push data", wr.data, 36'h07F);
        check("push ptr", ptr[35:24], 36'h008);
        working_register = 8'h5C;
        issue(16'h0014);
        check("call", call, 36'h1);
        check("call target", tgt, 36'h05C);
        check("call dead", ready, 36'h0);
        move(16'hEB05, 16'hF123, 8'hA5, 12'h00D);
        check("move dest", wr.addr, 36'h123);
        move(16'hEB83, 16'hF007, 8'h3C, 12'h00B);
        check("move dest", wr.addr, 36'h00F);
        issue(16'hF123);
        check("lone word", wr.en, 36'h0);
        check("lone ptr", ptr[35:24], 36'h008);
    endtask : t_extended_ops

    initial begin
        repeat (20) @(posedge clock);
        #1 srst = 1'b0;
        t_watchdog();
        t_ext_off();
        t_pointers();
        t_extended_ops();
        print_verdict();
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule : test_wdt_ext_core
